// [tb_timer8_ctrl_status_ch01.sv]
// Bench for the timer control/status block: AXI4-Lite tasks and channel events.
// Assumes the checker is compiled first; single 100 MHz clock.
module tb_timer8_ctrl_status_ch01
  import timer8_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, awv, awr, wv, wrd, bv, bry, arv, arr, rv, rry, pin0, pin1, conv, p0;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdt;
  logic [3:0]  ws;
  logic [1:0]  brs, rrs, bseen, r;
  logic [31:0] d;
  chan_in_t    ci [2];
  int          num_errors, total_checks, cyc;
  logic [1:0]  codes [5] = '{2'h2, 2'h3, 2'h0, 2'h1, 2'h3};

  timer8_ctrl_status_ch01 u_timer8_ctrl_status_ch01 (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(brs),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdt), .s_axi_rresp(rrs), .s_axi_rvalid(rv), .s_axi_rready(rry), .chan0_in(ci[0]),
    .chan1_in(ci[1]), .timer_out_pin_ch0(pin0), .timer_out_pin_ch1(pin1), .conv_start_req(conv));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Hang guard: the whole run needs well under this many cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge aclk);
    awa <= a;
    wd <= {24'h0, v};
    awv <= 1'b1;
    wv <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (awr && !ad) begin
        ad = 1'b1;
        awv <= 1'b0;
      end
      if (wrd && !dd) begin
        dd = 1'b1;
        wv <= 1'b0;
      end
    end
    while (!bv) @(posedge aclk);
    // Ready raised only after the answer is seen, so the answer must stand meanwhile
    bry <= 1'b1;
    @(posedge aclk);
    bseen = brs;
    bry <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    do @(posedge aclk); while (!arr);
    arv <= 1'b0;
    // Ready held back one cycle so the read answer must stand while unaccepted
    @(posedge aclk);
    rry <= 1'b1;
    do @(posedge aclk); while (!rv);
    v = rdt;
    rs = rrs;
    rry <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e, input string n);
    logic [31:0] v;
    logic [1:0]  rs;
    rd(a, v, rs);
    chk(n, v, {24'h0, e});
    chk("read resp", rs, RESP_OKAY);
  endtask

  // One counter update; returns at the falling edge when its effects have landed
  task ev(input int c, input logic [7:0] t, input logic [7:0] ka, input logic [7:0] kb);
    @(posedge aclk);
    ci[c] <= '{1'b1, t, ka, kb};
    @(posedge aclk);
    ci[c].count_upd <= 1'b0;
    @(negedge aclk);
  endtask

  function automatic logic nx(input logic [1:0] c, input logic p);
    case (c)
      2'h0: return p;
      2'h1: return 1'b0;
      2'h2: return 1'b1;
      default: return ~p;
    endcase
  endfunction

  initial begin
    {aresetn, awv, wv, bry, arv, rry, awa, ara, wd} = '0;
    ws = 4'hf;
    ci[0] = '0;
    ci[1] = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, reserved bit, writes of one, unmapped place
    rc(OFS_TSC_CH0, 8'h00, "ch0 reset");
    rc(OFS_TSC_CH1, 8'h10, "ch1 reset");
    wr(OFS_TSC_CH0, 8'he0);
    chk("write bresp", bseen, RESP_OKAY);
    rc(OFS_TSC_CH0, 8'h00, "flags after ones");
    wr(OFS_TSC_CH1, 8'h0f);
    rc(OFS_TSC_CH1, 8'h1f, "ch1 reserved");
    rd(8'h08, d, r);
    chk("unmapped rresp", r, RESP_DECERR);
    wr(8'h08, 8'hff);
    chk("unmapped bresp", bseen, RESP_DECERR);
    // A write without byte lane 0 is answered but changes nothing
    ws <= 4'he;
    wr(OFS_TSC_CH0, 8'h03);
    ws <= 4'hf;
    chk("no lane bresp", bseen, RESP_OKAY);
    rc(OFS_TSC_CH0, 8'h00, "no lane 0");
    $display("register test done");
    // Every pin action on match A, with the trigger on, then on match B
    p0 = 1'b0;
    foreach (codes[i]) begin
      wr(OFS_TSC_CH0, {6'h04, codes[i]});
      ev(0, 8'h20, 8'h20, 8'h77);
      p0 = nx(codes[i], p0);
      chk("pin0 match a", pin0, p0);
      chk("conv on", conv, 1'b1);
    end
    foreach (codes[i]) begin
      wr(OFS_TSC_CH0, {4'h0, codes[i], 2'h0});
      ev(0, 8'h30, 8'h20, 8'h30);
      p0 = nx(codes[i], p0);
      chk("pin0 match b", pin0, p0);
      chk("conv off", conv, 1'b0);
    end
    $display("action test done");
    // Flags: set, clear after read, no clear without read, event beats clear
    rc(OFS_TSC_CH0, 8'hcc, "ch0 match flags");
    wr(OFS_TSC_CH0, 8'h0c);
    rc(OFS_TSC_CH0, 8'h0c, "cleared");
    ev(0, 8'h20, 8'h20, 8'h77);
    wr(OFS_TSC_CH0, 8'h0c);
    rc(OFS_TSC_CH0, 8'h4c, "unarmed clear");
    fork
      wr(OFS_TSC_CH0, 8'h0c);
      begin
        @(posedge aclk);
        ev(0, 8'h20, 8'h20, 8'h77);
      end
    join
    rc(OFS_TSC_CH0, 8'h4c, "event wins");
    $display("flag test done");
    // Channel 1 on its own inputs, then a wrap from the top count
    wr(OFS_TSC_CH1, 8'h03);
    ev(1, 8'h11, 8'h11, 8'h99);
    chk("pin1 toggle", pin1, 1'b1);
    chk("pin0 untouched", pin0, p0);
    chk("no conv ch1", conv, 1'b0);
    ev(1, 8'hff, 8'h11, 8'h99);
    ev(1, 8'h00, 8'h11, 8'h99);
    rc(OFS_TSC_CH1, 8'h73, "ch1 flags");
    $display("channel 1 test done");
    wrap_up();
  end
endmodule

bind timer8_ctrl_status_ch01 timer8_chk u_timer8_chk (.*);

// [timer8_chan.sv]
// One channel: status flags, pin action select, optional conversion trigger.
// Assumes the counter advances elsewhere and reports each new value with count_upd.
module timer8_chan
  import timer8_pkg::*;
#(
  parameter bit HAS_TRIG = 1'b1
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire chan_in_t   cin,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  input  wire logic       rd_en,
  output logic [7:0]      status,
  output logic            pin,
  output logic            conv_req
);

  logic       flag_b_r, flag_b_nxt;
  logic       flag_a_r, flag_a_nxt;
  logic       flag_w_r, flag_w_nxt;
  logic       arm_b_r, arm_b_nxt;
  logic       arm_a_r, arm_a_nxt;
  logic       arm_w_r, arm_w_nxt;
  logic       trig_en_r, trig_en_nxt;
  logic [1:0] act_b_r, act_b_nxt;
  logic [1:0] act_a_r, act_a_nxt;
  logic [7:0] prev_r, prev_nxt;
  logic       pin_r, pin_nxt;
  logic       conv_r, conv_nxt;
  logic       hit_a;
  logic       hit_b;
  logic       hit_w;
  logic [1:0] act;

  // Strongest action wins when both matches coincide: toggle, then high, then low
  function automatic logic [1:0] strongest(input logic [1:0] x, input logic [1:0] y);
    strongest = (x > y) ? x : y;
  endfunction

  // Flag update: the set term is ORed last so an event is never lost to a clear
  function automatic logic flag_next(input logic flag, input logic hit, input logic arm,
                                     input logic wr, input logic wbit);
    flag_next = (flag & ~(wr & arm & ~wbit)) | hit;
  endfunction

  assign status = {flag_b_r, flag_a_r, flag_w_r, (HAS_TRIG ? trig_en_r : RSVD_BIT4_VAL),
                   act_b_r, act_a_r};  // [R8]
  assign pin      = pin_r;
  assign conv_req = conv_r;

  // Event detection and next state of all channel registers
  always_comb begin
    hit_b = cin.count_upd && (cin.timer_count == cin.compare_const_b);  // [R1] [R9]
    hit_a = cin.count_upd && (cin.timer_count == cin.compare_const_a);  // [R2] [R9]
    hit_w = cin.count_upd && (cin.timer_count == COUNT_ZERO) && (prev_r == COUNT_MAX);  // [R3]
    prev_nxt = cin.count_upd ? cin.timer_count : prev_r;

    // Clearing needs a prior read that saw the flag set; writing one never sets it
    flag_b_nxt = flag_next(flag_b_r, hit_b, arm_b_r, wr_en, wr_data[BIT_MATCH_B]);  // [R4] [R10]
    flag_a_nxt = flag_next(flag_a_r, hit_a, arm_a_r, wr_en, wr_data[BIT_MATCH_A]);  // [R4] [R10]
    flag_w_nxt = flag_next(flag_w_r, hit_w, arm_w_r, wr_en, wr_data[BIT_WRAP]);     // [R4] [R10]

    // A read arms each set flag; any later write consumes the arming
    arm_b_nxt = wr_en ? 1'b0 : (arm_b_r | (rd_en & flag_b_r));  // [R4]
    arm_a_nxt = wr_en ? 1'b0 : (arm_a_r | (rd_en & flag_a_r));
    arm_w_nxt = wr_en ? 1'b0 : (arm_w_r | (rd_en & flag_w_r));

    trig_en_nxt = trig_en_r;
    act_b_nxt   = act_b_r;
    act_a_nxt   = act_a_r;
    if (wr_en) begin
      trig_en_nxt = HAS_TRIG ? wr_data[BIT_TRIG_EN] : 1'b0;  // [R8]
      act_b_nxt   = wr_data[BIT_ACT_B_HI:BIT_ACT_B_LO];
      act_a_nxt   = wr_data[BIT_ACT_A_HI:BIT_ACT_A_LO];
    end

    // Pin action, using settings in force before this cycle's write
    act = strongest(hit_b ? act_b_r : ACT_NONE, hit_a ? act_a_r : ACT_NONE);  // [R6] [R7]
    case (act)
      ACT_LOW:    pin_nxt = 1'b0;
      ACT_HIGH:   pin_nxt = 1'b1;
      ACT_TOGGLE: pin_nxt = ~pin_r;
      default:    pin_nxt = pin_r;
    endcase

    conv_nxt = HAS_TRIG && trig_en_r && hit_a;  // [R5]
  end

  // Registers only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_b_r  <= TSC_RESET[BIT_MATCH_B];
      flag_a_r  <= TSC_RESET[BIT_MATCH_A];
      flag_w_r  <= TSC_RESET[BIT_WRAP];
      arm_b_r   <= 1'b0;
      arm_a_r   <= 1'b0;
      arm_w_r   <= 1'b0;
      trig_en_r <= TSC_RESET[BIT_TRIG_EN];
      act_b_r   <= ACT_RESET;
      act_a_r   <= ACT_RESET;
      prev_r    <= COUNT_ZERO;
      pin_r     <= 1'b0;
      conv_r    <= 1'b0;
    end else begin
      flag_b_r  <= flag_b_nxt;
      flag_a_r  <= flag_a_nxt;
      flag_w_r  <= flag_w_nxt;
      arm_b_r   <= arm_b_nxt;
      arm_a_r   <= arm_a_nxt;
      arm_w_r   <= arm_w_nxt;
      trig_en_r <= trig_en_nxt;
      act_b_r   <= act_b_nxt;
      act_a_r   <= act_a_nxt;
      prev_r    <= prev_nxt;
      pin_r     <= pin_nxt;
      conv_r    <= conv_nxt;
    end
  end

endmodule

// [timer8_chk.sv]
// Checker for the two-channel timer control/status block.
// Sees only top-level ports; one clock domain, reset active low.
module timer8_chk
  import timer8_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire chan_in_t          chan0_in,
  input wire chan_in_t          chan1_in,
  input wire logic              timer_out_pin_ch0,
  input wire logic              timer_out_pin_ch1,
  input wire logic              conv_start_req
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic rd_ch1_r;
  // Match causes, sampled one cycle later by the pin and trigger checks
  wire logic m0a = chan0_in.count_upd && chan0_in.timer_count == chan0_in.compare_const_a;
  wire logic m0 = m0a || (chan0_in.count_upd && chan0_in.timer_count == chan0_in.compare_const_b);
  wire logic m1 = chan1_in.count_upd && (chan1_in.timer_count == chan1_in.compare_const_a
                  || chan1_in.timer_count == chan1_in.compare_const_b);
  // Remember which register the pending read targets
  always_ff @(posedge aclk)
    if (s_axi_arvalid && s_axi_arready) rd_ch1_r <= (s_axi_araddr == OFS_TSC_CH1);
  trig_cause_a: assert property (conv_start_req |-> $past(m0a))
    else $error("conversion request without match A");
  pin0_cause_a: assert property ($changed(timer_out_pin_ch0) |-> $past(m0))
    else $error("pin 0 moved without a match");
  pin1_cause_a: assert property ($changed(timer_out_pin_ch1) |-> $past(m1))
    else $error("pin 1 moved without a match");
  rsvd_bit_a: assert property (s_axi_rvalid && rd_ch1_r |-> s_axi_rdata[4])
    else $error("reserved bit read as zero");
  r_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  cover property (conv_start_req);
  cover property (s_axi_bvalid && s_axi_bresp == RESP_DECERR);
  cover property ($changed(timer_out_pin_ch1));
endmodule

// [timer8_ctrl_status_ch01.sv]
// Control and status for two 8-bit timer channels behind an AXI4-Lite slave.
// Assumes counters and compare constants live elsewhere and arrive as chan_in_t.
//
// Contract
// [R1] A channel's match B flag (bit 7) sets whenever its counter equals compare constant B.
// [R2] A channel's match A flag (bit 6) sets whenever its counter equals compare constant A.
// [R3] A channel's wrap flag (bit 5) sets when its counter goes from its maximum to zero.
// [R4] A flag clears only by reading it as one and then writing zero; writing one never sets it.
// [R5] On channel 0, bit 4 enables a conversion start request on each match A.
// [R6] On match B, bits 3:2 leave, lower, raise or toggle the channel's output pin.
// [R7] On match A, bits 1:0 act on the output pin with the same encoding.
// [R8] On channel 1, bit 4 always reads as one and ignores writes.
// [R9] Channel 1 behaves like channel 0 with its own counter, constants and pin.
// [R10] A flag event in the same cycle as a clearing write leaves the flag set.
module timer8_ctrl_status_ch01
  import timer8_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire chan_in_t          chan0_in,
  input  wire chan_in_t          chan1_in,
  output logic                   timer_out_pin_ch0,
  output logic                   timer_out_pin_ch1,
  output logic                   conv_start_req
);

  logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [7:0]        wdata_r, wdata_nxt;
  logic              wlane_r, wlane_nxt;
  logic              aw_got_r, aw_got_nxt;
  logic              w_got_r, w_got_nxt;
  logic              awready_r, awready_nxt;
  logic              wready_r, wready_nxt;
  logic              bvalid_r, bvalid_nxt;
  logic [1:0]        bresp_r, bresp_nxt;
  logic              arready_r, arready_nxt;
  logic              rvalid_r, rvalid_nxt;
  logic [31:0]       rdata_r, rdata_nxt;
  logic [1:0]        rresp_r, rresp_nxt;
  logic              do_write;
  logic              do_read;
  reg_sel_t          wsel;
  reg_sel_t          rsel;
  logic              wr0, wr1, rd0, rd1;
  logic [7:0]        stat0, stat1;

  // Word-aligned decode shared by both paths
  function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
    if (addr == OFS_TSC_CH0) begin
      decode = SEL_CH0;
    end else if (addr == OFS_TSC_CH1) begin
      decode = SEL_CH1;
    end else begin
      decode = SEL_NONE;
    end
  endfunction

  // Write channel: address and data held independently, response after both
  always_comb begin
    awaddr_nxt = awaddr_r;
    wdata_nxt  = wdata_r;
    wlane_nxt  = wlane_r;
    aw_got_nxt = aw_got_r;
    w_got_nxt  = w_got_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt  = bresp_r;
    do_write   = aw_got_r && w_got_r && !bvalid_r;
    wsel       = decode(awaddr_r);
    if (s_axi_awvalid && awready_r) begin
      awaddr_nxt = s_axi_awaddr;
      aw_got_nxt = 1'b1;
    end
    if (s_axi_wvalid && wready_r) begin
      wdata_nxt = s_axi_wdata[7:0];
      wlane_nxt = s_axi_wstrb[0];
      w_got_nxt = 1'b1;
    end
    if (do_write) begin
      aw_got_nxt = 1'b0;
      w_got_nxt  = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = (wsel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    // Hold off new traffic until the response has gone
    awready_nxt = !aw_got_nxt && !bvalid_nxt && !do_write;
    wready_nxt  = !w_got_nxt && !bvalid_nxt && !do_write;
  end

  // A write without byte lane 0 touches nothing in these 8-bit registers
  assign wr0 = do_write && wlane_r && (wsel == SEL_CH0);
  assign wr1 = do_write && wlane_r && (wsel == SEL_CH1);

  // Read channel: data captured at the address handshake
  always_comb begin
    do_read     = s_axi_arvalid && arready_r;
    rsel        = decode(s_axi_araddr);
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    if (do_read) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = (rsel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
      if (rsel == SEL_CH0) begin
        rdata_nxt = {24'h000000, stat0};
      end else if (rsel == SEL_CH1) begin
        rdata_nxt = {24'h000000, stat1};
      end else begin
        rdata_nxt = 32'h00000000;
      end
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    arready_nxt = !rvalid_nxt;
  end

  // The read that returns a set flag is what arms its clear
  assign rd0 = do_read && (rsel == SEL_CH0);  // [R4]
  assign rd1 = do_read && (rsel == SEL_CH1);  // [R4]

  // Bus registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_r  <= '0;
      wdata_r   <= TSC_RESET;
      wlane_r   <= 1'b0;
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h00000000;
      rresp_r   <= RESP_OKAY;
    end else begin
      awaddr_r  <= awaddr_nxt;
      wdata_r   <= wdata_nxt;
      wlane_r   <= wlane_nxt;
      aw_got_r  <= aw_got_nxt;
      w_got_r   <= w_got_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // Channel 0 carries the conversion trigger
  timer8_chan #(
    .HAS_TRIG (1'b1)
  ) u_ch0 (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .cin      (chan0_in),
    .wr_en    (wr0),
    .wr_data  (wdata_r),
    .rd_en    (rd0),
    .status   (stat0),
    .pin      (timer_out_pin_ch0),
    .conv_req (conv_start_req)
  );  // [R5]

  // Channel 1 is independent; bit 4 is fixed at one
  timer8_chan #(
    .HAS_TRIG (1'b0)
  ) u_ch1 (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .cin      (chan1_in),
    .wr_en    (wr1),
    .wr_data  (wdata_r),
    .rd_en    (rd1),
    .status   (stat1),
    .pin      (timer_out_pin_ch1),
    .conv_req ()
  );  // [R9] [R8]

endmodule

// [timer8_pkg.sv]
// Shared constants and carrier types for the two-channel 8-bit timer control/status block.
// Assumes a single 100 MHz clock and an AXI4-Lite register bus with 32-bit data.
package timer8_pkg;

  // Register map, byte addresses
  localparam int unsigned ADDR_W         = 8;
  localparam logic [7:0]  OFS_TSC_CH0    = 8'h00;
  localparam logic [7:0]  OFS_TSC_CH1    = 8'h04;

  // Field positions inside a timer_status_ctrl register
  localparam int unsigned BIT_MATCH_B    = 7;
  localparam int unsigned BIT_MATCH_A    = 6;
  localparam int unsigned BIT_WRAP       = 5;
  localparam int unsigned BIT_TRIG_EN    = 4;
  localparam int unsigned BIT_ACT_B_HI   = 3;
  localparam int unsigned BIT_ACT_B_LO   = 2;
  localparam int unsigned BIT_ACT_A_HI   = 1;
  localparam int unsigned BIT_ACT_A_LO   = 0;

  // Reset values and fixed bits
  localparam logic [7:0]  TSC_RESET      = 8'h00;
  localparam logic        RSVD_BIT4_VAL  = 1'b1;
  localparam logic [1:0]  ACT_RESET      = 2'h0;

  // Counter limits
  localparam logic [7:0]  COUNT_MAX      = 8'hff;
  localparam logic [7:0]  COUNT_ZERO     = 8'h00;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_DECERR    = 2'h3;

  // Pin action on a compare match
  typedef enum logic [1:0] {
    ACT_NONE   = 2'h0,
    ACT_LOW    = 2'h1,
    ACT_HIGH   = 2'h2,
    ACT_TOGGLE = 2'h3
  } pin_action_t;

  // Inputs from the counter and compare registers of one channel
  typedef struct packed {
    logic       count_upd;        // Counter took a new value this cycle
    logic [7:0] timer_count;
    logic [7:0] compare_const_a;
    logic [7:0] compare_const_b;
  } chan_in_t;

  // Register selection result of the address decoder
  typedef enum logic [2:0] {
    SEL_NONE = 3'b001,
    SEL_CH0  = 3'b010,
    SEL_CH1  = 3'b100
  } reg_sel_t;

endpackage
